// >>> sync_sram_fifo_port.sv
// Synchronous memory port: burst SRAM, ZBT SRAM or synchronous FIFO access.
// Assumes both interface clocks arrive from outside and are sampled on REF_CLK.
//
// How it works
// R1: Read latency of zero to three interface cycles per chip-enable space.
// R2: Write latency of zero to three interface cycles per chip-enable space.
// R3: With extend clear, chip select drops right after the last command.
// R4: With extend set, chip select stays active while output enable is active.
// R5: Read-enable mode clear: strobe is address strobe, deselect cycle inserted.
// R6: Read-enable mode set: strobe is FIFO read enable, no deselect cycle.
// R7: Interface runs from external clock one or two, per clock select.
// R8: Shared strobe pins act as strobe, output enable and write enable.
// R9: Five settings held in a writable secondary control word per space.
// R10: Latency counted in interface edges; read data sampled at the final edge.
`timescale 1ns/1ns
`default_nettype none
module sync_sram_fifo_port (
    input  wire logic                                REF_CLK,
    input  wire logic                                RESET,
    input  wire logic                                EXT_CLOCK_OUT_ONE,
    input  wire logic                                EXT_CLOCK_OUT_TWO,
    input  wire logic                                SEC_WRITE,
    input  wire logic [sync_port_pkg::SPACE_W-1:0]   SEC_SPACE,
    input  wire logic [sync_port_pkg::SEC_W-1:0]     SEC_WDATA,
    output logic      [sync_port_pkg::SEC_W-1:0]     SEC_RDATA,
    input  wire logic                                REQ_VALID,
    output logic                                     REQ_READY,
    input  wire logic                                REQ_WRITE,
    input  wire logic [sync_port_pkg::SPACE_W-1:0]   REQ_SPACE,
    input  wire logic [sync_port_pkg::ADDR_W-1:0]    REQ_ADDR,
    input  wire logic [sync_port_pkg::DATA_W-1:0]    REQ_WDATA,
    input  wire logic [sync_port_pkg::BE_W-1:0]      REQ_BE,
    output logic                                     RD_VALID,
    input  wire logic                                RD_READY,
    output logic      [sync_port_pkg::DATA_W-1:0]    RD_DATA,
    output logic                                     BUSY,
    output logic      [sync_port_pkg::SPACE_NUM-1:0] SPACE_CHIP_SELECT_N,
    output logic      [sync_port_pkg::ADDR_W-1:0]    EXT_ADDRESS_BUS,
    output logic      [sync_port_pkg::BE_W-1:0]      BYTE_ENABLE_N,
    output logic      [sync_port_pkg::DATA_W-1:0]    EXT_DATA_BUS_O,
    output logic                                     EXT_DATA_BUS_OE,
    input  wire logic [sync_port_pkg::DATA_W-1:0]    EXT_DATA_BUS_I,
    output logic                                     SYNC_ADDRESS_STROBE_N,
    output logic                                     SYNC_OUTPUT_ENABLE_N,
    output logic                                     SYNC_WRITE_ENABLE_N
);
    import sync_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [SPACE_NUM-1:0][SEC_W-1:0] sec;
        logic [1:0]          ck1;
        logic [1:0]          ck2;
        logic                ck_last;
        seq_state_e          state;
        logic                wr;
        logic [SPACE_W-1:0]  space;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [BE_W-1:0]     be;
        logic [LAT_W-1:0]    lat;
        logic [DATA_W-1:0]   rdata;
        logic                rpush;
        logic [SPACE_NUM-1:0] cs_n;
        logic [ADDR_W-1:0]   ea;
        logic [BE_W-1:0]     be_n;
        logic [DATA_W-1:0]   ed_o;
        logic                ed_oe;
        logic                ads_n;
        logic                oe_n;
        logic                we_n;
        logic                busy;
        logic [SEC_W-1:0]    sec_rd;
    } port_s;

    port_s st_reg;
    port_s st_next;
    logic  buf_ready;
    logic  sel_clk;
    logic  edge_now;
    logic  chip_select_extend;
    logic  read_enable_mode;
    logic [LAT_W-1:0] rl;
    logic [LAT_W-1:0] wl;

    // Picks one field of a space's control word.
    function automatic logic [LAT_W-1:0] lat_field(input logic [SEC_W-1:0] w, input int lsb);
        lat_field = w[lsb +: LAT_W];
    endfunction

    // Chip-select vector with only the chosen space asserted low.
    function automatic logic [SPACE_NUM-1:0] cs_vec(input logic [SPACE_W-1:0] s);
        cs_vec = ~(SPACE_NUM'(1) << s);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Read-data buffer so a stalled consumer loses no word.

    sync_skid_buf #(
        .WIDTH (DATA_W)
    ) u_rbuf (
        .clk       (REF_CLK),
        .reset     (RESET),
        .in_valid  (st_reg.rpush),
        .in_ready  (buf_ready),
        .in_data   (st_reg.rdata),
        .out_valid (RD_VALID),
        .out_ready (RD_READY),
        .out_data  (RD_DATA)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        st_next = st_reg;
        st_next.rpush = 1'b0;
        // Two-flop synchronisers for both external clocks.
        st_next.ck1 = {st_reg.ck1[0], EXT_CLOCK_OUT_ONE};
        st_next.ck2 = {st_reg.ck2[0], EXT_CLOCK_OUT_TWO};
        chip_select_extend = st_reg.sec[st_reg.space][SEC_CHIP_SELECT_EXTEND_BIT];
        read_enable_mode = st_reg.sec[st_reg.space][SEC_REN_BIT];
        rl = lat_field(st_reg.sec[st_reg.space], SEC_RL_LSB);
        wl = lat_field(st_reg.sec[st_reg.space], SEC_WL_LSB);
        // Interface clock chosen per space, rising edge found on REF_CLK.
        sel_clk = st_reg.sec[st_reg.space][SEC_CLK_BIT] ? st_reg.ck2[1] : st_reg.ck1[1]; // R7
        st_next.ck_last = sel_clk;
        edge_now = sel_clk && !st_reg.ck_last;

        // Software writes a secondary control word at any time.
        if (SEC_WRITE) begin
            st_next.sec[SEC_SPACE] = SEC_WDATA; // R9
        end
        st_next.sec_rd = st_next.sec[SEC_SPACE];

        if (edge_now) begin
            case (st_reg.state)
                ST_IDLE: begin
                    st_next.cs_n  = '1;
                    st_next.ads_n = 1'b1;
                    st_next.oe_n  = 1'b1;
                    st_next.we_n  = 1'b1;
                    st_next.ed_oe = 1'b0;
                    if (REQ_VALID && buf_ready) begin
                        st_next.wr    = REQ_WRITE;
                        st_next.space = REQ_SPACE;
                        st_next.addr  = REQ_ADDR;
                        st_next.wdata = REQ_WDATA;
                        st_next.be    = REQ_BE;
                        st_next.busy  = 1'b1;
                        st_next.state = ST_CMD;
                    end
                end
                ST_CMD: begin
                    // Command edge: chip select, address, strobe and enables.
                    st_next.cs_n  = cs_vec(st_reg.space);
                    st_next.ea    = st_reg.addr;
                    st_next.be_n  = ~st_reg.be;
                    st_next.ads_n = 1'b0; // R8
                    st_next.oe_n  = st_reg.wr;
                    st_next.we_n  = !st_reg.wr;
                    st_next.ed_oe = st_reg.wr && (wl == '0); // R2
                    st_next.ed_o  = st_reg.wdata;
                    st_next.lat   = st_reg.wr ? wl : rl; // R1 R2
                    st_next.state = ((st_reg.wr ? wl : rl) == '0) ? ST_DATA : ST_LAT;
                end
                ST_LAT: begin
                    // Command done: drop address strobe and write enable; drop select unless extended.
                    st_next.ads_n = 1'b1;
                    st_next.we_n  = 1'b1;
                    if (!chip_select_extend) begin
                        st_next.cs_n = '1; // R3
                    end
                    st_next.lat = st_reg.lat - LAT_W'(1); // R10
                    if (st_reg.lat == LAT_W'(1)) begin
                        st_next.ed_oe = st_reg.wr;
                        st_next.state = ST_DATA;
                    end
                end
                ST_DATA: begin
                    // Data edge: sample read data or end the write drive.
                    if (!st_reg.wr) begin
                        st_next.rdata = EXT_DATA_BUS_I; // R10
                        st_next.rpush = 1'b1;
                    end
                    st_next.ads_n = 1'b1;
                    st_next.we_n  = 1'b1;
                    st_next.oe_n  = 1'b1;
                    st_next.ed_oe = 1'b0;
                    st_next.cs_n  = '1; // R3 R4
                    st_next.state = read_enable_mode ? ST_IDLE : ST_DESEL; // R5 R6
                    st_next.busy  = !read_enable_mode;
                end
                ST_DESEL: begin
                    // Deselect cycle before the next command.
                    st_next.busy  = 1'b0;
                    st_next.state = ST_IDLE; // R5
                end
                default: begin
                    st_next.state = ST_IDLE;
                end
            endcase
            // While extended, select is kept active while output enable is active.
            if (chip_select_extend && !st_next.oe_n) begin
                st_next.cs_n = cs_vec(st_reg.space); // R4
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            st_reg <= '0;
            // Synchronisers keep sampling and the detector starts high, so no false edge.
            st_reg.ck1     <= st_next.ck1;
            st_reg.ck2     <= st_next.ck2;
            st_reg.ck_last <= 1'b1;
            st_reg.sec   <= {SPACE_NUM{SEC_RESET}};
            st_reg.state <= ST_IDLE;
            st_reg.cs_n  <= '1;
            st_reg.be_n  <= '1;
            st_reg.ads_n <= 1'b1;
            st_reg.oe_n  <= 1'b1;
            st_reg.we_n  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register, except REQ_READY, which also needs buffer room.
    assign SEC_RDATA             = st_reg.sec_rd;
    assign REQ_READY             = (st_reg.state == ST_IDLE) && !st_reg.busy && buf_ready;
    assign BUSY                  = st_reg.busy;
    assign SPACE_CHIP_SELECT_N   = st_reg.cs_n;
    assign EXT_ADDRESS_BUS       = st_reg.ea;
    assign BYTE_ENABLE_N         = st_reg.be_n;
    assign EXT_DATA_BUS_O        = st_reg.ed_o;
    assign EXT_DATA_BUS_OE       = st_reg.ed_oe;
    assign SYNC_ADDRESS_STROBE_N = st_reg.ads_n; // R8
    assign SYNC_OUTPUT_ENABLE_N  = st_reg.oe_n; // R8
    assign SYNC_WRITE_ENABLE_N   = st_reg.we_n; // R8
endmodule
`default_nettype wire

// >>> sync_port_pkg.sv
// Constants and types shared by the synchronous memory port.
// Assumes a single 125 MHz core clock and externally supplied interface clocks.
package sync_port_pkg;

    // Widths of the external buses and of the latency fields.
    localparam int ADDR_W    = 20;
    localparam int DATA_W    = 16;
    localparam int BE_W      = 2;
    localparam int LAT_W     = 2;
    localparam int SPACE_NUM = 4;
    localparam int SPACE_W   = 2;

    // Field positions inside one secondary control word.
    localparam int SEC_W         = 7;
    localparam int SEC_RL_LSB    = 0;
    localparam int SEC_WL_LSB    = 2;
    localparam int SEC_CHIP_SELECT_EXTEND_BIT = 4;
    localparam int SEC_REN_BIT   = 5;
    localparam int SEC_CLK_BIT   = 6;
    localparam logic [SEC_W-1:0] SEC_RESET = 7'h00;

    // Buffer entry count at which the buffer is full.
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_LAT,
        ST_DATA,
        ST_DESEL
    } seq_state_e;

endpackage

// >>> sync_skid_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes the same clock on both sides and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module sync_skid_buf #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    import sync_port_pkg::*;

    // Elaboration check: a zero-width word cannot be stored.
    if (WIDTH < 1) begin : g_width_check
        $error("Buffer width must be at least one.");
    end

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  wr;
        logic                  rd;
        logic [1:0]            count;
    } buf_s;

    buf_s st_reg;
    buf_s st_next;
    logic push;
    logic pop;

    // Push and pop follow the handshakes; full refuses input.
    always_comb begin
        st_next = st_reg;
        push = in_valid && (st_reg.count != BUF_DEPTH);
        pop  = out_ready && (st_reg.count != 2'h0);
        if (push) begin
            st_next.mem[st_reg.wr] = in_data;
            st_next.wr = ~st_reg.wr;
        end
        if (pop) begin
            st_next.rd = ~st_reg.rd;
        end
        st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
    end

    // State register.
    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_ready  = (st_reg.count != BUF_DEPTH);
    assign out_valid = (st_reg.count != 2'h0);
    assign out_data  = st_reg.mem[st_reg.rd];
endmodule
`default_nettype wire

// >>> sync_sram_fifo_port_asserts.sv
// Checker for the pins of the synchronous memory port.
// Assumes the bench keeps the control read port on space 0.
`timescale 1ns/1ns
`default_nettype none
module sync_port_asserts (
    input wire logic        REF_CLK,
    input wire logic        RESET,
    input wire logic        SEC_WRITE,
    input wire logic [6:0]  SEC_WDATA,
    input wire logic [6:0]  SEC_RDATA,
    input wire logic        REQ_READY,
    input wire logic        RD_VALID,
    input wire logic        RD_READY,
    input wire logic [15:0] RD_DATA,
    input wire logic        BUSY,
    input wire logic [3:0]  SPACE_CHIP_SELECT_N,
    input wire logic        EXT_DATA_BUS_OE,
    input wire logic        SYNC_ADDRESS_STROBE_N,
    input wire logic        SYNC_OUTPUT_ENABLE_N,
    input wire logic        SYNC_WRITE_ENABLE_N
);
////////////////////////////////////////////////////////////////
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    // Pin roles, select timing and buffer holding, tied to their causes.
    a_reset_idle: assert property (disable iff (1'b0)
        RESET |=> &SPACE_CHIP_SELECT_N && SYNC_OUTPUT_ENABLE_N && !EXT_DATA_BUS_OE)
        else $error("outputs not idle after reset");
    a_oe_we_excl: assert property (!(!SYNC_OUTPUT_ENABLE_N && !SYNC_WRITE_ENABLE_N))
        else $error("output and write enable both active");
    a_strobe_cs: assert property (!SYNC_ADDRESS_STROBE_N |-> SPACE_CHIP_SELECT_N == 4'he)
        else $error("strobe without its chip select");
    a_cs_drop: assert property (!SEC_RDATA[4] && $rose(SYNC_ADDRESS_STROBE_N)
        |-> SPACE_CHIP_SELECT_N[0]) else $error("chip select held after command");
    a_cs_extend: assert property (SEC_RDATA[4] && !SYNC_OUTPUT_ENABLE_N
        |-> !SPACE_CHIP_SELECT_N[0]) else $error("chip select not extended");
    a_deselect_gap: assert property (!SEC_RDATA[5] && $rose(SPACE_CHIP_SELECT_N[0])
        |=> SPACE_CHIP_SELECT_N[0] [*8]) else $error("no deselect cycle");
    a_wdata_now: assert property (!SYNC_WRITE_ENABLE_N && SEC_RDATA[3:2] == 2'h0
        |-> EXT_DATA_BUS_OE) else $error("write data missing at latency zero");
    a_wdata_late: assert property (!SYNC_WRITE_ENABLE_N && SEC_RDATA[3:2] != 2'h0
        |-> !EXT_DATA_BUS_OE) else $error("write data before its latency");
    a_sec_store: assert property (SEC_WRITE |=> SEC_RDATA == $past(SEC_WDATA))
        else $error("control word not stored");
    a_rd_hold: assert property (RD_VALID && !RD_READY |=> RD_VALID && $stable(RD_DATA))
        else $error("read word lost while stalled");
    a_ready_idle: assert property (REQ_READY
        |-> &SPACE_CHIP_SELECT_N && SYNC_ADDRESS_STROBE_N && SYNC_OUTPUT_ENABLE_N
            && SYNC_WRITE_ENABLE_N && !EXT_DATA_BUS_OE) else $error("pins active while ready");
endmodule
bind sync_sram_fifo_port sync_port_asserts i_chk (.REF_CLK(REF_CLK), .RESET(RESET),
    .SEC_WRITE(SEC_WRITE), .SEC_WDATA(SEC_WDATA), .SEC_RDATA(SEC_RDATA),
    .REQ_READY(REQ_READY), .RD_VALID(RD_VALID), .RD_READY(RD_READY), .RD_DATA(RD_DATA),
    .BUSY(BUSY), .SPACE_CHIP_SELECT_N(SPACE_CHIP_SELECT_N), .EXT_DATA_BUS_OE(EXT_DATA_BUS_OE),
    .SYNC_ADDRESS_STROBE_N(SYNC_ADDRESS_STROBE_N),
    .SYNC_OUTPUT_ENABLE_N(SYNC_OUTPUT_ENABLE_N), .SYNC_WRITE_ENABLE_N(SYNC_WRITE_ENABLE_N));
`default_nettype wire

// >>> sync_mem_model.sv
// Behavioural pipelined memory on the far side of the port.
// Assumes one access at a time and latencies handed in by the bench.
`timescale 1ns/1ns
`default_nettype none
module sync_mem_model (
    input  wire logic        clk,
    input  wire logic        cs_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] din,
    input  wire logic [1:0]  rl,
    input  wire logic [1:0]  wl,
    output logic      [15:0] dout
);
    logic [15:0] mem [16];
    logic [3:0]  a = 4'h0;
    logic [3:0]  rp = 4'h0;
    logic [3:0]  wp = 4'h0;
    initial dout = 16'h0;
    // Commands enter a pipe; data moves only when the pipe reaches the latency.
    always @(posedge clk) begin
        rp = {rp[2:0], !cs_n && !oe_n};
        wp = {wp[2:0], !cs_n && !we_n};
        if (rp[0] || wp[0])
            a = addr;
        if (wp[wl])
            mem[a] = din;
        dout <= rp[rl] ? mem[a] : ~dout; // Released bus shows the inverse.
    end
endmodule
`default_nettype wire

// >>> sync_sram_fifo_port_tb_top.sv
// Self-checking bench for the synchronous memory port.
// Assumes the bound checker and the memory model on space 0.
`timescale 1ns/1ns
`default_nettype none
module sync_sram_fifo_port_tb_top;
    import sync_port_pkg::*;
    typedef struct packed {
        logic [6:0]  c;
        logic [19:0] a;
        logic [15:0] d;
    } row_t;
    logic        clk = 1'b0, rst = 1'b1, c1 = 1'b0, c2 = 1'b0, run2 = 1'b0;
    logic        sec_write = 1'b0, req_valid = 1'b0, req_write = 1'b0, rd_ready = 1'b0;
    logic [1:0]  sec_space = 2'h0;
    logic [6:0]  cur = 7'h0, sec_wdata = 7'h0;
    logic [15:0] req_wdata = 16'h0;
    logic [19:0] req_addr = 20'h0;
    logic        req_ready, rd_valid, busy, d_oe, ads_n, oe_n, we_n;
    logic [2:0]  st;
    logic [1:0]  be_n;
    logic [3:0]  cs_n;
    logic [6:0]  sec_rdata;
    logic [15:0] rd_data, d_o, m_d, bus;
    logic [19:0] ext_addr;
    int          err_count = 0, samples_checked = 0;
    row_t        rows [4];
////////////////////////////////////////////////////////////////
    // Core clock, and two interface clocks of 80 ns; clock two runs on demand.
    always #4 clk = ~clk;
    always #40 c1 <= #3 ~c1;
    always #40 c2 = run2 & ~c2;
    assign bus = d_oe ? d_o : m_d;
    assign st = {req_ready, rd_valid, busy};
    sync_sram_fifo_port i_dut (.REF_CLK(clk), .RESET(rst), .EXT_CLOCK_OUT_ONE(c1),
        .EXT_CLOCK_OUT_TWO(c2), .SEC_WRITE(sec_write), .SEC_SPACE(sec_space),
        .SEC_WDATA(sec_wdata), .SEC_RDATA(sec_rdata), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_SPACE(2'h0), .REQ_ADDR(req_addr),
        .REQ_WDATA(req_wdata), .REQ_BE(2'h3), .RD_VALID(rd_valid), .RD_READY(rd_ready),
        .RD_DATA(rd_data), .BUSY(busy), .SPACE_CHIP_SELECT_N(cs_n), .EXT_ADDRESS_BUS(ext_addr),
        .BYTE_ENABLE_N(be_n), .EXT_DATA_BUS_O(d_o), .EXT_DATA_BUS_OE(d_oe), .EXT_DATA_BUS_I(bus),
        .SYNC_ADDRESS_STROBE_N(ads_n), .SYNC_OUTPUT_ENABLE_N(oe_n), .SYNC_WRITE_ENABLE_N(we_n));
    sync_mem_model i_mem (.clk(cur[6] ? c2 : c1), .cs_n(cs_n[0]), .oe_n(oe_n), .we_n(we_n),
        .addr(ext_addr[3:0]), .din(bus), .rl(cur[1:0]), .wl(cur[3:2]), .dout(m_d));
    // Verdict, comparison and bounded waiting.
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wt(input int k, input logic v);
        for (int i = 0; i < 500 && st[k] !== v; i++)
            tick(1);
        if (st[k] !== v) begin
            err_count++;
            $display("ERROR wait %0d expected %h seen %h", k, v, st[k]);
            test_done();
        end
    endtask
    // Control word write with read-back, one access, and one read word.
    task automatic cfg(input logic [1:0] s, input logic [6:0] w);
        cur = w;
        sec_space = s;
        sec_wdata = w;
        sec_write = 1'b1;
        tick(1);
        sec_write = 1'b0;
        tick(1);
        chk("control word", {9'h0, w}, {9'h0, sec_rdata});
    endtask
    task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d);
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        wt(0, 1'b1);
        req_valid = 1'b0;
        wt(0, 1'b0);
    endtask
    task automatic rd(input logic [15:0] e);
        wt(1, 1'b1);
        chk("read data", e, rd_data);
        rd_ready = 1'b1;
        tick(1);
        rd_ready = 1'b0;
        tick(1);
    endtask
    task automatic rchk;
        rst = 1'b1;
        tick(5);
        rst = 1'b0;
        chk("idle pins", 16'h7f00, {rd_valid, cs_n, ads_n, oe_n, we_n, d_oe, sec_rdata});
        chk("idle byte enables", 16'h0003, {14'h0, be_n});
    endtask
    // Per-space words, table of modes, full buffer, clock two, second reset.
    initial begin
        rows = '{'{7'h00, 20'h00003, 16'h5a3c}, '{7'h15, 20'h0000c, 16'hc3a5},
                 '{7'h2a, 20'hfffff, 16'h0ff0}, '{7'h3f, 20'h12345, 16'hf00f}};
        rchk();
        for (int s = 3; s >= 0; s--)
            cfg(2'(s), {2'(s), 5'h0a});
        for (int s = 1; s < 4; s++) begin
            sec_space = 2'(s);
            tick(2);
            chk("space word", {9'h0, 2'(s), 5'h0a}, {9'h0, sec_rdata});
        end
        foreach (rows[i]) begin
            cfg(2'h0, rows[i].c);
            acc(1'b1, rows[i].a, rows[i].d);
            chk("byte enables", 16'h0, {14'h0, be_n});
            chk("address", rows[i].a[19:4], ext_addr[19:4]);
            acc(1'b0, rows[i].a, 16'h0);
            rd(rows[i].d);
        end
        acc(1'b0, 20'h00003, 16'h0);
        acc(1'b0, 20'h0000c, 16'h0);
        req_valid = 1'b1;
        tick(40);
        chk("refused when full", 16'h0, {14'h0, req_ready, busy});
        req_valid = 1'b0;
        rd(16'h5a3c);
        rd(16'hc3a5);
        cfg(2'h0, 7'h40);
        req_write = 1'b0;
        req_addr = 20'h0000f;
        req_valid = 1'b1;
        tick(60);
        chk("stopped clock two", 16'h001e, {11'h0, cs_n, busy});
        run2 = 1'b1;
        wt(0, 1'b1);
        req_valid = 1'b0;
        rd(16'h0ff0);
        rchk();
        test_done();
    end
endmodule
`default_nettype wire
